// [dpp_map.svh]
`ifndef DPP_MAP_SVH
`define DPP_MAP_SVH

// ----------------------------------------------------------------
// Register port
// ----------------------------------------------------------------
`define DPP_ADDR_W 8
`define DPP_DATA_W 32
`define DPP_OFF_PINCFG 8'h00
`define DPP_OFF_USEROUT 8'h04
`define DPP_OFF_USERIN 8'h08
`define DPP_OFF_PROBE 8'h0C
`define DPP_RDATA_RST 32'h0000_0000

// ----------------------------------------------------------------
// Pins: 0 global clock, 1 diagnostic clock, 2 serial in, 3 probe a, 4 probe b
// ----------------------------------------------------------------
`define DPP_NPINS 5
`define DPP_PIN_GCLK 0
`define DPP_PIN_DIAGNOSTIC_CLOCK 1
`define DPP_PIN_SDI 2
`define DPP_PIN_PRA 3
`define DPP_PIN_PRB 4
`define DPP_CFG_W 3
`define DPP_PINCFG_W 15
`define DPP_PINCFG_RST 15'h0000
`define DPP_DIAG_PIN_MASK 5'h1E
`define DPP_DIAG_OUT_MASK 5'h18
`define DPP_OE_LSB 8
`define DPP_UOUT_RST 5'h00

// ----------------------------------------------------------------
// Probe select and lock
// ----------------------------------------------------------------
`define DPP_NODES 16
`define DPP_SEL_W 4
`define DPP_FRAME_W 8
`define DPP_CNT_W 3
`define DPP_CNT_LAST 3'h7
`define DPP_CNT_ONE 3'h1
`define DPP_FRAME_RST 8'h00
`define DPP_LOCK_BIT 0
`define DPP_MODE_BIT 1
`define DPP_SELA_LSB 4
`define DPP_SELB_LSB 8

`endif

// [dpp_pkg.sv]
package dpp_pkg;

   typedef enum logic [2:0] {
      DPP_PIN_UNUSED,
      DPP_PIN_INPUT,
      DPP_PIN_OUTPUT,
      DPP_PIN_TRISTATE,
      DPP_PIN_BIDIR,
      DPP_PIN_CLKIN
   } dpp_pin_cfg_e;

endpackage : dpp_pkg

// [dpp_pin_cell.sv]
`timescale 1ns/1ps
`include "dpp_map.svh"

module dpp_pin_cell (
   input wire logic clk,
   input wire logic rst,
   input dpp_pkg::dpp_pin_cfg_e cfg,
   input wire logic diag_on,
   input wire logic diag_out,
   input wire logic diag_val,
   input wire logic user_out,
   input wire logic user_oe,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic user_in
);
   import dpp_pkg::*;

   logic out_ff;
   logic oe_ff;
   logic nxt_out;
   logic nxt_oe;
   logic in_s1_ff;
   logic in_s2_ff;

   // ----------------------------------------------------------------
   // Output driver
   // ----------------------------------------------------------------
   always_comb begin
      nxt_out = 1'b0;
      nxt_oe = 1'b0;
      if (diag_on) begin
         // Diagnostic inputs float so the external tool can drive them
         nxt_oe = diag_out;
         nxt_out = diag_out & diag_val;
      end else begin
         unique case (cfg)
            DPP_PIN_UNUSED: begin
               nxt_oe = 1'b1;
               nxt_out = 1'b0;
            end
            DPP_PIN_INPUT, DPP_PIN_CLKIN: begin
               nxt_oe = 1'b0;
               nxt_out = 1'b0;
            end
            DPP_PIN_OUTPUT: begin
               nxt_oe = 1'b1;
               nxt_out = user_out;
            end
            DPP_PIN_TRISTATE, DPP_PIN_BIDIR: begin
               nxt_oe = user_oe;
               nxt_out = user_out;
            end
            default: begin
               // Illegal code: park like an unused pin
               nxt_oe = 1'b1;
               nxt_out = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_ff <= 1'b0;
         oe_ff <= 1'b1;
         in_s1_ff <= 1'b0;
         in_s2_ff <= 1'b0;
      end else begin
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
         in_s1_ff <= pin_in;
         in_s2_ff <= in_s1_ff;
      end
   end

   assign pin_out = out_ff;
   assign pin_oe = oe_ff;
   assign user_in = in_s2_ff;

endmodule : dpp_pin_cell

// [dpp_top.sv]
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`include "dpp_map.svh"

// Operation
// - With the mode pin high the clock, serial and probe pins take their diagnostic roles.
// - With the mode pin low those four pins behave as ordinary user I/O.
// - Two independent probe outputs each show one selected internal node in real time.
// - A permanent lock stops any internal node from reaching either probe output.
// - Each probe pin can be a general user I/O once debugging is finished.
// - The global clock pin feeds the clock network or may be used as general I/O; here its clock-input setting only floats the pin like an input.
// - Each user pin may be an input, output, three-state output or bidirectional buffer.
// - A user pin left unused by the design is driven low.
module dpp_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`DPP_ADDR_W-1:0] reg_addr,
   input wire logic [`DPP_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`DPP_DATA_W-1:0] reg_rdata,
   input wire logic mode_pin,
   input wire logic [`DPP_NODES-1:0] internal_nodes,
   input wire logic diagnostic_clock,
   output logic diagnostic_clock_out,
   output logic diagnostic_clock_oe,
   input wire logic serial_diag_in,
   output logic serial_diag_in_out,
   output logic serial_diag_in_oe,
   input wire logic probe_out_a_in,
   output logic probe_out_a,
   output logic probe_out_a_oe,
   input wire logic probe_out_b_in,
   output logic probe_out_b,
   output logic probe_out_b_oe,
   input wire logic gclk_pin_in,
   output logic gclk_pin_out,
   output logic gclk_pin_oe,
   output logic [`DPP_NPINS-1:0] user_pin_in
);
   import dpp_pkg::*;

   // ----------------------------------------------------------------
   // Link domain: serial select shifter on the diagnostic clock
   // ----------------------------------------------------------------
   logic lmode_s1_ff;
   logic lmode_s2_ff;
   logic [`DPP_FRAME_W-1:0] shift_ff;
   logic [`DPP_FRAME_W-1:0] nxt_shift;
   logic [`DPP_CNT_W-1:0] cnt_ff;
   logic [`DPP_CNT_W-1:0] nxt_cnt;
   logic [`DPP_FRAME_W-1:0] hold_ff;
   logic [`DPP_FRAME_W-1:0] nxt_hold;
   logic tog_ff;
   logic nxt_tog;

   // While mode is low this pin is user I/O and may toggle freely; the synced
   // mode level keeps such edges from disturbing the select word.
   always_comb begin
      nxt_shift = shift_ff;
      nxt_cnt = cnt_ff;
      nxt_hold = hold_ff;
      nxt_tog = tog_ff;
      if (lmode_s2_ff) begin
         nxt_shift = {shift_ff[`DPP_FRAME_W-2:0], serial_diag_in};
         nxt_cnt = cnt_ff + `DPP_CNT_ONE;
         if (cnt_ff == `DPP_CNT_LAST) begin
            nxt_hold = {shift_ff[`DPP_FRAME_W-2:0], serial_diag_in};
            nxt_tog = ~tog_ff;
         end
      end else begin
         // Partial frames are dropped when mode falls
         nxt_cnt = '0;
      end
   end

   always_ff @(posedge diagnostic_clock or posedge rst) begin
      if (rst) begin
         lmode_s1_ff <= 1'b0;
         lmode_s2_ff <= 1'b0;
         shift_ff <= `DPP_FRAME_RST;
         cnt_ff <= '0;
         hold_ff <= `DPP_FRAME_RST;
         tog_ff <= 1'b0;
      end else begin
         lmode_s1_ff <= mode_pin;
         lmode_s2_ff <= lmode_s1_ff;
         shift_ff <= nxt_shift;
         cnt_ff <= nxt_cnt;
         hold_ff <= nxt_hold;
         tog_ff <= nxt_tog;
      end
   end

   // ----------------------------------------------------------------
   // Crossing into the core clock
   // ----------------------------------------------------------------
   logic mode_s1_ff;
   logic mode_s2_ff;
   logic tog_s1_ff;
   logic tog_s2_ff;
   logic tog_s3_ff;
   logic [`DPP_FRAME_W-1:0] sel_ff;
   logic [`DPP_FRAME_W-1:0] nxt_sel;

   // The held word is static for a full frame after each toggle, far longer
   // than the three core cycles the toggle needs to arrive.
   always_comb begin
      nxt_sel = sel_ff;
      // The link's own mode sync only drops on a later diagnostic clock edge, so
      // user activity on that pin could finish a stale partial frame.
      if ((tog_s2_ff != tog_s3_ff) && mode_s2_ff) begin
         nxt_sel = hold_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_s1_ff <= 1'b0;
         mode_s2_ff <= 1'b0;
         tog_s1_ff <= 1'b0;
         tog_s2_ff <= 1'b0;
         tog_s3_ff <= 1'b0;
         sel_ff <= `DPP_FRAME_RST;
      end else begin
         mode_s1_ff <= mode_pin;
         mode_s2_ff <= mode_s1_ff;
         tog_s1_ff <= tog_ff;
         tog_s2_ff <= tog_s1_ff;
         tog_s3_ff <= tog_s2_ff;
         sel_ff <= nxt_sel;
      end
   end

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   logic [`DPP_PINCFG_W-1:0] pincfg_ff;
   logic [`DPP_PINCFG_W-1:0] nxt_pincfg;
   logic [`DPP_NPINS-1:0] uout_ff;
   logic [`DPP_NPINS-1:0] nxt_uout;
   logic [`DPP_NPINS-1:0] uoe_ff;
   logic [`DPP_NPINS-1:0] nxt_uoe;
   logic lock_ff;
   logic nxt_lock;
   logic [`DPP_DATA_W-1:0] rdata_ff;
   logic [`DPP_DATA_W-1:0] nxt_rdata;
   logic [`DPP_NPINS-1:0] uin;
   logic [`DPP_SEL_W-1:0] sel_a;
   logic [`DPP_SEL_W-1:0] sel_b;

   assign sel_a = sel_ff[`DPP_SEL_W-1:0];
   assign sel_b = sel_ff[`DPP_FRAME_W-1:`DPP_SEL_W];

   always_comb begin
      nxt_pincfg = pincfg_ff;
      nxt_uout = uout_ff;
      nxt_uoe = uoe_ff;
      nxt_lock = lock_ff;
      nxt_rdata = `DPP_RDATA_RST;
      if (reg_wr) begin
         unique case (reg_addr)
            `DPP_OFF_PINCFG: begin
               nxt_pincfg = reg_wdata[`DPP_PINCFG_W-1:0];
            end
            `DPP_OFF_USEROUT: begin
               nxt_uout = reg_wdata[`DPP_NPINS-1:0];
               nxt_uoe = reg_wdata[`DPP_OE_LSB+`DPP_NPINS-1:`DPP_OE_LSB];
            end
            `DPP_OFF_PROBE: begin
               // Writing zero never clears the lock; only a device reset does
               nxt_lock = lock_ff | reg_wdata[`DPP_LOCK_BIT];
            end
            default: begin
               nxt_lock = lock_ff;
            end
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `DPP_OFF_PINCFG: begin
               nxt_rdata[`DPP_PINCFG_W-1:0] = pincfg_ff;
            end
            `DPP_OFF_USEROUT: begin
               nxt_rdata[`DPP_NPINS-1:0] = uout_ff;
               nxt_rdata[`DPP_OE_LSB+`DPP_NPINS-1:`DPP_OE_LSB] = uoe_ff;
            end
            `DPP_OFF_USERIN: begin
               nxt_rdata[`DPP_NPINS-1:0] = uin;
            end
            `DPP_OFF_PROBE: begin
               nxt_rdata[`DPP_LOCK_BIT] = lock_ff;
               nxt_rdata[`DPP_MODE_BIT] = mode_s2_ff;
               // Select readback is hidden once locked to keep the design private
               nxt_rdata[`DPP_SELA_LSB+`DPP_SEL_W-1:`DPP_SELA_LSB] =
                  lock_ff ? '0 : sel_a;
               nxt_rdata[`DPP_SELB_LSB+`DPP_SEL_W-1:`DPP_SELB_LSB] =
                  lock_ff ? '0 : sel_b;
            end
            default: begin
               nxt_rdata = `DPP_RDATA_RST;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pincfg_ff <= `DPP_PINCFG_RST;
         uout_ff <= `DPP_UOUT_RST;
         uoe_ff <= `DPP_UOUT_RST;
         lock_ff <= 1'b0;
         rdata_ff <= `DPP_RDATA_RST;
      end else begin
         pincfg_ff <= nxt_pincfg;
         uout_ff <= nxt_uout;
         uoe_ff <= nxt_uoe;
         lock_ff <= nxt_lock;
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // ----------------------------------------------------------------
   // Probe selection and pin cells
   // ----------------------------------------------------------------
   logic [`DPP_NPINS-1:0] pin_in_v;
   logic [`DPP_NPINS-1:0] pin_out_v;
   logic [`DPP_NPINS-1:0] pin_oe_v;
   logic [`DPP_NPINS-1:0] diag_val_v;
   logic [`DPP_NPINS-1:0] diag_on_v;
   logic [`DPP_NPINS-1:0] diag_out_mask;

   assign pin_in_v[`DPP_PIN_GCLK] = gclk_pin_in;
   assign pin_in_v[`DPP_PIN_DIAGNOSTIC_CLOCK] = diagnostic_clock;
   assign pin_in_v[`DPP_PIN_SDI] = serial_diag_in;
   assign pin_in_v[`DPP_PIN_PRA] = probe_out_a_in;
   assign pin_in_v[`DPP_PIN_PRB] = probe_out_b_in;

   // A locked probe shows constant low instead of any node
   always_comb begin
      diag_val_v = '0;
      diag_val_v[`DPP_PIN_PRA] = internal_nodes[sel_a] & ~lock_ff;
      diag_val_v[`DPP_PIN_PRB] = internal_nodes[sel_b] & ~lock_ff;
   end

   assign diag_on_v = {`DPP_NPINS{mode_s2_ff}} & `DPP_DIAG_PIN_MASK;
   assign diag_out_mask = `DPP_DIAG_OUT_MASK;

   genvar gi;
   generate
      for (gi = 0; gi < `DPP_NPINS; gi++) begin : g_pin
         dpp_pin_cell u_cell (
            .clk(clk),
            .rst(rst),
            .cfg(dpp_pin_cfg_e'(pincfg_ff[gi*`DPP_CFG_W +: `DPP_CFG_W])),
            .diag_on(diag_on_v[gi]),
            .diag_out(diag_out_mask[gi]),
            .diag_val(diag_val_v[gi]),
            .user_out(uout_ff[gi]),
            .user_oe(uoe_ff[gi]),
            .pin_in(pin_in_v[gi]),
            .pin_out(pin_out_v[gi]),
            .pin_oe(pin_oe_v[gi]),
            .user_in(uin[gi])
         );
      end
   endgenerate

   assign gclk_pin_out = pin_out_v[`DPP_PIN_GCLK];
   assign gclk_pin_oe = pin_oe_v[`DPP_PIN_GCLK];
   assign diagnostic_clock_out = pin_out_v[`DPP_PIN_DIAGNOSTIC_CLOCK];
   assign diagnostic_clock_oe = pin_oe_v[`DPP_PIN_DIAGNOSTIC_CLOCK];
   assign serial_diag_in_out = pin_out_v[`DPP_PIN_SDI];
   assign serial_diag_in_oe = pin_oe_v[`DPP_PIN_SDI];
   assign probe_out_a = pin_out_v[`DPP_PIN_PRA];
   assign probe_out_a_oe = pin_oe_v[`DPP_PIN_PRA];
   assign probe_out_b = pin_out_v[`DPP_PIN_PRB];
   assign probe_out_b_oe = pin_oe_v[`DPP_PIN_PRB];
   assign user_pin_in = uin;

endmodule : dpp_top

// [dpp_checker.sv]
`timescale 1ns/1ps
`include "dpp_map.svh"

module dpp_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`DPP_ADDR_W-1:0] reg_addr,
   input wire logic [`DPP_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`DPP_DATA_W-1:0] reg_rdata,
   input wire logic mode_pin,
   input wire logic diagnostic_clock_oe,
   input wire logic serial_diag_in_oe,
   input wire logic probe_out_a,
   input wire logic probe_out_a_oe,
   input wire logic probe_out_b,
   input wire logic probe_out_b_oe,
   input wire logic gclk_pin_out,
   input wire logic gclk_pin_oe
);
   logic [14:0] cfg_ff;
   logic [14:0] nxt_cfg;
   logic [12:0] uo_ff;
   logic [12:0] nxt_uo;
   logic lock_ff;
   logic nxt_lock;

   // ----------------------------------------------------------------
   // Shadow of software writes
   // ----------------------------------------------------------------
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_uo = uo_ff;
      nxt_lock = lock_ff;
      if (reg_wr && reg_addr == `DPP_OFF_PINCFG) nxt_cfg = reg_wdata[14:0];
      if (reg_wr && reg_addr == `DPP_OFF_USEROUT) nxt_uo = reg_wdata[12:0];
      if (reg_wr && reg_addr == `DPP_OFF_PROBE && reg_wdata[0]) nxt_lock = 1'b1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_ff <= 15'h0000;
         uo_ff <= 13'h0000;
         lock_ff <= 1'b0;
      end else begin
         cfg_ff <= nxt_cfg;
         uo_ff <= nxt_uo;
         lock_ff <= nxt_lock;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   chk_diag_inputs: assert property (
      mode_pin [*5] |-> !diagnostic_clock_oe && !serial_diag_in_oe)
      else $error("diag input pins still driven");
   chk_probe_drive: assert property (
      mode_pin [*5] |-> probe_out_a_oe && probe_out_b_oe)
      else $error("probe pins not driven in diag mode");
   chk_lock_quiet: assert property (
      mode_pin [*5] ##0 lock_ff [*3] |-> !probe_out_a && !probe_out_b)
      else $error("locked probe shows a node");
   chk_lock_hide: assert property (
      $past(reg_rd) && $past(reg_addr) == `DPP_OFF_PROBE && $past(lock_ff)
      |-> reg_rdata[11:4] == 8'h00 && reg_rdata[0])
      else $error("locked select readable");
   chk_unused_low: assert property (
      (cfg_ff[2:0] == 3'h0 || cfg_ff[2:0] > 3'h5) && $stable(cfg_ff)
      |=> gclk_pin_oe && !gclk_pin_out)
      else $error("unused pin not driven low");
   chk_clkin_float: assert property (
      cfg_ff[2:0] == 3'h5 && $stable(cfg_ff) |=> !gclk_pin_oe)
      else $error("clock input pin driven");
   chk_user_drive: assert property (
      cfg_ff[2:0] == 3'h2 && $stable(cfg_ff) && $stable(uo_ff)
      |=> gclk_pin_oe && gclk_pin_out == $past(uo_ff[0]))
      else $error("output pin wrong");
   chk_tri_drive: assert property (
      (cfg_ff[2:0] == 3'h3 || cfg_ff[2:0] == 3'h4) && $stable(cfg_ff) && $stable(uo_ff)
      |=> gclk_pin_oe == $past(uo_ff[8]) && gclk_pin_out == $past(uo_ff[0]))
      else $error("three-state pin wrong");
   chk_probe_user: assert property (
      (!mode_pin) [*5] ##0 (cfg_ff[11:9] == 3'h2 && $stable(cfg_ff) && $stable(uo_ff))
      |=> probe_out_a_oe && probe_out_a == $past(uo_ff[3]))
      else $error("probe pin not user output");
endmodule : dpp_checker

bind dpp_top dpp_checker dpp_checker_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .mode_pin, .diagnostic_clock_oe, .serial_diag_in_oe, .probe_out_a,
   .probe_out_a_oe, .probe_out_b, .probe_out_b_oe, .gclk_pin_out, .gclk_pin_oe);

// [dpp_tool_model.sv]
`timescale 1ns/1ps

module dpp_tool_model (
   output logic diag_clk,
   output logic diag_data
);
   initial begin
      diag_clk = 1'b0;
      diag_data = 1'b0;
   end

   // Clock stands still between frames; data flips after so a stale bit never looks held
   task automatic send_bits(input int n, input logic [7:0] bits);
      for (int i = n - 1; i >= 0; i--) begin
         diag_data = bits[i];
         #16;
         diag_clk = 1'b1;
         #32;
         diag_clk = 1'b0;
         #16;
      end
      diag_data = ~diag_data;
      #16;
   endtask : send_bits
endmodule : dpp_tool_model

// [dpp_top_tb.sv]
`timescale 1ns/1ps
`include "dpp_map.svh"

module dpp_top_tb;
   logic clk, rst, reg_wr, reg_rd, mode_pin, m_clk, m_data;
   logic [7:0] reg_addr, frame;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   logic [15:0] internal_nodes;
   wire [4:0] pin_out;
   wire [4:0] pin_oe;
   logic [4:0] pin_drv, wire_lvl, user_pin_in;
   logic [14:0] cfg;
   logic [12:0] uo;
   logic [1:0] exp2;
   int num_errors, n_checks, seed;

   // Wire level: design wins while it drives, else the outside party
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         wire_lvl[i] = pin_oe[i] ? pin_out[i] : ((i == 1) ? m_clk : (i == 2) ? m_data : pin_drv[i]);
      end
   end

   dpp_tool_model dpp_tool_model_i (.diag_clk(m_clk), .diag_data(m_data));

   dpp_top dpp_top_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_pin(mode_pin),
      .internal_nodes(internal_nodes), .diagnostic_clock(wire_lvl[1]),
      .diagnostic_clock_out(pin_out[1]), .diagnostic_clock_oe(pin_oe[1]),
      .serial_diag_in(wire_lvl[2]), .serial_diag_in_out(pin_out[2]),
      .serial_diag_in_oe(pin_oe[2]), .probe_out_a_in(wire_lvl[3]), .probe_out_a(pin_out[3]),
      .probe_out_a_oe(pin_oe[3]), .probe_out_b_in(wire_lvl[4]), .probe_out_b(pin_out[4]),
      .probe_out_b_oe(pin_oe[4]), .gclk_pin_in(wire_lvl[0]), .gclk_pin_out(pin_out[0]),
      .gclk_pin_oe(pin_oe[0]), .user_pin_in(user_pin_in));

   always #4 clk = ~clk;

   // ----------------------------------------------------------------
   // Bench tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask : rd

   // Returns {oe, out}; out only matters while driven
   function automatic logic [1:0] pin_exp(input logic [2:0] c, input logic v, input logic e);
      case (c)
         3'h1, 3'h5: pin_exp = 2'b00;
         3'h2: pin_exp = {1'b1, v};
         3'h3, 3'h4: pin_exp = {e, v};
         default: pin_exp = 2'b10;
      endcase
   endfunction : pin_exp

   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run

   initial begin
      #300000;
      num_errors++;
      complete_run();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {reg_wr, reg_rd, mode_pin} = 3'b000;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      internal_nodes = 16'h0;
      pin_drv = 5'h00;
      seed = 32'hE10353E0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1;
      check({pin_oe, pin_out}, 10'h3E0, "reset pins");
      rd(8'h10, rd_val);
      check(rd_val, 32'h0, "unmapped read");
      for (int it = 0; it < 24; it++) begin
         @(posedge clk);
         cfg = $random(seed);
         if (it < 8) cfg[2:0] = it[2:0];
         uo = $random(seed);
         pin_drv <= $random(seed);
         wr(`DPP_OFF_PINCFG, {17'h0, cfg});
         wr(`DPP_OFF_USEROUT, {19'h0, uo});
         repeat (4) @(posedge clk);
         #1;
         for (int i = 0; i < 5; i++) begin
            exp2 = pin_exp(cfg[3*i+:3], uo[i], uo[8+i]);
            check({pin_oe[i], pin_oe[i] & pin_out[i]}, {exp2[1], &exp2}, "pin");
         end
         rd(`DPP_OFF_USERIN, rd_val);
         check(rd_val, {27'h0, wire_lvl}, "user inputs");
         check(user_pin_in, wire_lvl, "user pin port");
      end
      @(posedge clk);
      mode_pin <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check(pin_oe[4:1], 4'hC, "diag pin roles");
      dpp_tool_model_i.send_bits(2, 8'h00);
      for (int k = 0; k < 8; k++) begin
         frame = (k == 0) ? 8'h0F : (k == 1) ? 8'hF0 : (k == 2) ? 8'hFF : $random(seed);
         dpp_tool_model_i.send_bits(8, frame);
         repeat (8) @(posedge clk);
         internal_nodes <= $random(seed);
         @(posedge clk);
         #1;
         check(pin_out[3], internal_nodes[frame[3:0]], "probe a");
         check(pin_out[4], internal_nodes[frame[7:4]], "probe b");
         rd(`DPP_OFF_PROBE, rd_val);
         check(rd_val, {20'h0, frame, 4'h2}, "select readback");
      end
      wr(`DPP_OFF_PROBE, 32'h1);
      wr(`DPP_OFF_PROBE, 32'h0);
      @(posedge clk);
      internal_nodes <= 16'hFFFF;
      repeat (3) @(posedge clk);
      #1;
      check(pin_out[4:3], 2'b00, "locked probes");
      rd(`DPP_OFF_PROBE, rd_val);
      check(rd_val, 32'h3, "lock sticky");
      @(posedge clk);
      mode_pin <= 1'b0;
      wr(`DPP_OFF_PINCFG, 32'h400);
      wr(`DPP_OFF_USEROUT, 32'h8);
      repeat (6) @(posedge clk);
      #1;
      check({pin_oe[3], pin_out[3]}, 2'b11, "probe as user pin");
      complete_run();
   end
endmodule : dpp_top_tb
